// File: hdl/pmt_defs.svh
// Purpose: offsets, bit positions, widths and reset values of the pm1 control/timer block
// Assumes: byte-wide system i/o accesses relative to a programmable block base
// Notes: definitions only
`ifndef PMT_DEFS_SVH
`define PMT_DEFS_SVH

`define PMT_ADDR_W 16
`define PMT_OFS_EN_UPPER 4'h3
`define PMT_OFS_CTRL_LOW 4'h4
`define PMT_OFS_CTRL_2ND 4'h5
`define PMT_OFS_CTRL_3RD 4'h6
`define PMT_OFS_CTRL_4TH 4'h7
`define PMT_OFS_TMR_LOW 4'h8
`define PMT_OFS_TMR_MID 4'h9
`define PMT_OFS_TMR_HIGH 4'hA
`define PMT_OFS_TMR_TOP 4'hB
`define PMT_OFS_LAST 4'hB

`define PMT_BIT_SCI_SELECT 0
`define PMT_BIT_BM_RELOAD 1
`define PMT_BIT_GLOBAL_RELEASE 2

`define PMT_TMR_W 24
`define PMT_TMR_MSB 23
`define PMT_TMR_FREQ_HZ 3579545
`define PMT_TMR_RESET 24'h00_0000
`define PMT_CTRL_RESET 3'h0
`define PMT_BYTE_ZERO 8'h00

`endif

// File: hdl/pmt_pkg.sv
// Purpose: types shared by the pm1 control/timer block
// Assumes: pmt_defs.svh supplies all numbers
// Notes: control register low byte carried as one packed struct
package pmt_pkg;

  // writable bits of the control low byte, bit 0 at the bottom
  typedef struct packed {
    logic global_release;
    logic bus_master_reload_enable;
    logic sci_select;
  } pmt_ctrl_t;

endpackage

// File: hdl/pmt_pm1_timer.sv
// Purpose: pm1 control low byte, 24-bit pm timer with carry status, sci/smi routing
// Assumes: i/o strobes come from logic on clk_i; chip_input_clock_i is a slow pin
// Notes: master reset is sys_rst_i; timer ticks on rising edges of the synced pin clock
// What this block does
// - 24-bit timer counts only in working state
// - reset clears timer, then counts while clocked
// - stopped input clock holds count, resumes later
// - bit 23 toggle either way sets carry
// - carry enable plus carry status raises sci when sci select is set, or smi when sci select is clear and smi route enable is set
// - timer bytes readable at 8h, 9h, ah
// - sci select picks sci, else smi route
// - reload enable and bus master control interrupt
// - global release with firmware enable raises smi
// - reserved offsets and bits read zero
// - carry status cleared only by its clear input or master reset
// - release sets status; status clear clears both
// - timer run bit gates the timer
// - bus master interrupt is an sci when sci select is set, else an smi if smi route enable is set
`include "pmt_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module pmt_pm1_timer
  import pmt_pkg::*;
#(
  // only the default width gives the bit-23 carry; a narrower timer lets a
  // short run reach carry and wrap
  parameter int unsigned TMR_W = `PMT_TMR_W
)
(
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic [`PMT_ADDR_W-1:0] io_base_i,
  input wire logic [`PMT_ADDR_W-1:0] io_addr_i,
  input wire logic io_rd_i,
  input wire logic io_wr_i,
  input wire logic [7:0] io_wdata_i,
  output logic [7:0] io_rdata_o,
  output logic io_hit_o,
  input wire logic chip_input_clock_i,
  input wire logic working_state_i,
  input wire logic timer_run_i,
  input wire logic timer_carry_enable_i,
  input wire logic timer_carry_status_clr_i,
  input wire logic smi_route_enable_i,
  input wire logic bus_master_control_i,
  input wire logic firmware_release_enable_i,
  input wire logic firmware_release_status_clr_i,
  output logic timer_carry_status_o,
  output logic firmware_release_status_o,
  output logic global_release_o,
  output logic sci_o,
  output logic smi_o
);

  // true when an increment carries out of the bits below the top, i.e. the top bit flips
  function automatic logic msb_flips(input logic [TMR_W-1:0] v);
    msb_flips = &v[TMR_W-2:0];
  endfunction

  localparam int unsigned FULL_W = `PMT_TMR_W;

  logic [2:0] clk_sync_q;
  logic [1:0] work_sync_q;
  logic [TMR_W-1:0] count_q;
  logic [FULL_W-1:0] count_full;
  pmt_ctrl_t ctrl_q;
  logic tcs_q;
  logic fws_q;
  logic tick;
  logic [`PMT_ADDR_W-1:0] ofs_full;
  logic in_block;
  logic [3:0] ofs;
  logic ctrl_wr;
  logic rel_set;
  logic pm_event;

  // pin clock and working level pass two flops; bit 2 only serves edge detection
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      clk_sync_q <= 3'h0;
      work_sync_q <= 2'h0;
    end else begin
      clk_sync_q <= {clk_sync_q[1:0], chip_input_clock_i};
      work_sync_q <= {work_sync_q[0], working_state_i};
    end
  end

  // a stopped pin clock gives no edges, so the count simply holds
  assign tick = clk_sync_q[1] & ~clk_sync_q[2] & work_sync_q[1] & timer_run_i;

  // free-running counter, cleared only by master reset
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      count_q <= TMR_W'(`PMT_TMR_RESET);
    end else if (tick) begin
      count_q <= count_q + TMR_W'(24'h00_0001);
    end
  end

  // read view is always three bytes; a narrower timer reads zero above its top
  assign count_full = FULL_W'(count_q);

  // carry status: hardware set beats a software clear in the same cycle
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      tcs_q <= 1'b0;
    end else if (tick && msb_flips(count_q)) begin
      tcs_q <= 1'b1;
    end else if (timer_carry_status_clr_i) begin
      tcs_q <= 1'b0;
    end
  end

  // address decode relative to the programmable base
  assign ofs_full = io_addr_i - io_base_i;
  assign in_block = (ofs_full <= {{(`PMT_ADDR_W-4){1'b0}}, `PMT_OFS_LAST});
  assign ofs = ofs_full[3:0];
  assign ctrl_wr = io_wr_i && in_block && (ofs == `PMT_OFS_CTRL_LOW);
  assign rel_set = ctrl_wr && io_wdata_i[`PMT_BIT_GLOBAL_RELEASE];

  // control low byte; global release is set by writing one, cleared via status
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ctrl_q <= `PMT_CTRL_RESET;
    end else begin
      if (ctrl_wr) begin
        ctrl_q.sci_select <= io_wdata_i[`PMT_BIT_SCI_SELECT];
        ctrl_q.bus_master_reload_enable <= io_wdata_i[`PMT_BIT_BM_RELOAD];
      end
      if (rel_set) begin
        ctrl_q.global_release <= 1'b1;
      end else if (firmware_release_status_clr_i) begin
        ctrl_q.global_release <= 1'b0;
      end
    end
  end

  // firmware release status follows a set of global release; set wins over clear
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      fws_q <= 1'b0;
    end else if (rel_set) begin
      fws_q <= 1'b1;
    end else if (firmware_release_status_clr_i) begin
      fws_q <= 1'b0;
    end
  end

  // read data registered one cycle after the strobe; reserved space reads zero
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      io_rdata_o <= `PMT_BYTE_ZERO;
      io_hit_o <= 1'b0;
    end else begin
      io_hit_o <= io_rd_i && in_block && (ofs >= `PMT_OFS_EN_UPPER);
      io_rdata_o <= `PMT_BYTE_ZERO;
      if (io_rd_i && in_block) begin
        unique case (ofs)
          `PMT_OFS_CTRL_LOW: io_rdata_o <= {5'h00, ctrl_q};
          `PMT_OFS_TMR_LOW: io_rdata_o <= count_full[7:0];
          `PMT_OFS_TMR_MID: io_rdata_o <= count_full[15:8];
          `PMT_OFS_TMR_HIGH: io_rdata_o <= count_full[23:16];
          default: io_rdata_o <= `PMT_BYTE_ZERO;
        endcase
      end
    end
  end

  // power-management events: enabled timer carry and bus-master reload
  assign pm_event = (timer_carry_enable_i & tcs_q)
    | (ctrl_q.bus_master_reload_enable & bus_master_control_i);

  // interrupt routing; release-to-firmware always goes to smi
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      sci_o <= 1'b0;
      smi_o <= 1'b0;
      timer_carry_status_o <= 1'b0;
      firmware_release_status_o <= 1'b0;
      global_release_o <= 1'b0;
    end else begin
      sci_o <= pm_event & ctrl_q.sci_select;
      smi_o <= (pm_event & ~ctrl_q.sci_select & smi_route_enable_i)
        | (ctrl_q.global_release & firmware_release_enable_i);
      timer_carry_status_o <= tcs_q;
      firmware_release_status_o <= fws_q;
      global_release_o <= ctrl_q.global_release;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);

  sequence tick_at_flip_s;
    tick && msb_flips(count_q);
  endsequence

  count_step_a: assert property (tick |=> count_q == $past(count_q) + TMR_W'(24'h00_0001))
    else $error("timer did not advance by one on tick");
  count_hold_a: assert property (!tick |=> count_q == $past(count_q))
    else $error("timer moved without a tick");
  run_gate_a: assert property (!timer_run_i |=> $stable(count_q))
    else $error("timer moved while turned off");
  carry_set_a: assert property (tick_at_flip_s |=> tcs_q ##1 timer_carry_status_o)
    else $error("bit 23 flip did not set carry status");
  wrap_zero_a: assert property (tick && &count_q |=> count_q == TMR_W'(`PMT_TMR_RESET) && tcs_q)
    else $error("timer did not wrap to zero with carry");
  carry_sticky_a: assert property (tcs_q && !timer_carry_status_clr_i |=> tcs_q)
    else $error("carry status lost without a clear");
  tmr_sci_a: assert property (ctrl_q.sci_select && timer_carry_enable_i && tcs_q
    |=> sci_o && !(smi_o && !ctrl_q.global_release && !$past(ctrl_q.global_release)))
    else $error("enabled carry did not raise sci");
  bm_sci_a: assert property (ctrl_q.sci_select && ctrl_q.bus_master_reload_enable
    && bus_master_control_i |=> sci_o)
    else $error("bus master reload did not raise sci");
  route_smi_a: assert property (!ctrl_q.sci_select && smi_route_enable_i && pm_event
    |=> smi_o && !sci_o)
    else $error("event not routed to smi");
  rel_smi_a: assert property (rel_set && firmware_release_enable_i
    |=> fws_q ##1 (smi_o || !firmware_release_enable_i || !ctrl_q.global_release))
    else $error("global release did not raise smi");
  rel_clear_a: assert property (firmware_release_status_clr_i && !rel_set
    |=> !fws_q && !ctrl_q.global_release)
    else $error("status clear left release bits set");
  rsvd_zero_a: assert property (io_rd_i && in_block && (ofs == `PMT_OFS_TMR_TOP
    || ofs == `PMT_OFS_EN_UPPER || ofs == `PMT_OFS_CTRL_3RD) |=> io_rdata_o == 8'h00)
    else $error("reserved byte read nonzero");
  tmr_read_a: assert property (io_rd_i && in_block && ofs == `PMT_OFS_TMR_HIGH
    |=> io_rdata_o == $past(count_full[23:16]))
    else $error("timer high byte read wrong");

endmodule // pmt_pm1_timer
`default_nettype wire

// File: tb/pmt_tb.sv
// Purpose: self-checking bench for the pm1 control/timer block
// Assumes: 50 MHz clk_i, inputs driven 1 ns after rising edges
// Notes: timer shortened to 12 bits so its top-bit carry and wrap fit in the run
`timescale 1ns/1ps
`default_nettype none
`include "pmt_defs.svh"

module testbench;
  import pmt_pkg::*;
  localparam logic [15:0] BASE = 16'h0400;
  typedef struct packed {
    logic [1:0] ctrl;
    logic bm, smi_route_enable, fw_en, sci, smi;
  } pmt_row_t;
  logic clk_i = 0, sys_rst_i = 1, io_rd_i = 0, io_wr_i = 0, pin = 0, work = 0, run = 0;
  logic smi_route_enable = 0, bm = 0, fw_en = 0, fw_clr = 0;
  logic tce = 1, tcs_clr = 0;
  logic hit, tcs, frs, grel, sci, smi;
  logic [15:0] addr = 16'h0000;
  logic [7:0] wdata = 8'h00, rdata;
  int error_cnt = 0, compares = 0;
  // routing table: ctrl bits, bus master, smi route, fw enable, expected sci and smi
  pmt_row_t rows [7] = '{'{2'h3, 1'h1, 1'h0, 1'h0, 1'h1, 1'h0},
    '{2'h2, 1'h1, 1'h1, 1'h0, 1'h0, 1'h1}, '{2'h2, 1'h1, 1'h0, 1'h0, 1'h0, 1'h0},
    '{2'h3, 1'h0, 1'h1, 1'h0, 1'h0, 1'h0}, '{2'h1, 1'h1, 1'h1, 1'h0, 1'h0, 1'h0},
    '{2'h2, 1'h1, 1'h1, 1'h1, 1'h0, 1'h1}, '{2'h0, 1'h1, 1'h1, 1'h1, 1'h0, 1'h0}};

  always #10 clk_i = ~clk_i;

  pmt_pm1_timer #(.TMR_W(12))
    pmt_pm1_timer_inst (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .io_base_i(BASE),
    .io_addr_i(addr), .io_rd_i(io_rd_i), .io_wr_i(io_wr_i), .io_wdata_i(wdata),
    .io_rdata_o(rdata), .io_hit_o(hit), .chip_input_clock_i(pin), .working_state_i(work),
    .timer_run_i(run), .timer_carry_enable_i(tce), .timer_carry_status_clr_i(tcs_clr),
    .smi_route_enable_i(smi_route_enable), .bus_master_control_i(bm),
    .firmware_release_enable_i(fw_en), .firmware_release_status_clr_i(fw_clr),
    .timer_carry_status_o(tcs), .firmware_release_status_o(frs), .global_release_o(grel),
    .sci_o(sci), .smi_o(smi));

  task automatic finish_test();
    if (error_cnt == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask

  // strobes drop then one idle cycle, so no strobe is re-raised in the same step
  task automatic wr(input logic [3:0] ofs, input logic [7:0] d);
    addr = BASE + 16'(ofs);
    wdata = d;
    io_wr_i = 1;
    cyc(1);
    io_wr_i = 0;
    cyc(1);
  endtask

  task automatic rd(input logic [3:0] ofs, input logic [7:0] exp, input logic exp_hit);
    addr = BASE + 16'(ofs);
    io_rd_i = 1;
    cyc(1);
    io_rd_i = 0;
    chk(rdata, exp);
    chk({7'h00, hit}, {7'h00, exp_hit});
    cyc(1);
  endtask

  // pin clock high and low three system cycles each, idle low between calls
  task automatic tick(input int n);
    repeat (n) begin
      pin = 1;
      cyc(3);
      pin = 0;
      cyc(3);
    end
  endtask

  task automatic rel_clear();
    fw_clr = 1;
    cyc(1);
    fw_clr = 0;
    cyc(3);
    chk({5'h00, grel, frs, smi}, 8'h00);
  endtask

  initial begin
    repeat (100000) @(posedge clk_i);
    error_cnt++;
    finish_test();
  end

  initial begin
    cyc(6);
    sys_rst_i = 0;
    wr(4'h8, 8'hFF);
    wr(4'h3, 8'hFF);
    for (int o = 3; o <= 11; o++) rd(4'(o), 8'h00, 1'b1);
    rd(4'h0, 8'h00, 1'b0);
    rd(4'hC, 8'h00, 1'b0);
    foreach (rows[i]) begin
      bm = rows[i].bm;
      smi_route_enable = rows[i].smi_route_enable;
      fw_en = rows[i].fw_en;
      wr(4'h4, {6'h3E, rows[i].ctrl});
      cyc(2);
      chk({6'h00, sci, smi}, {6'h00, rows[i].sci, rows[i].smi});
      rd(4'h4, {6'h00, rows[i].ctrl}, 1'b1);
    end
    // global release with and without the firmware enable
    bm = 0;
    wr(4'h4, 8'h04);
    cyc(2);
    chk({5'h00, grel, frs, smi}, 8'h07);
    wr(4'h4, 8'h00);
    rd(4'h4, 8'h04, 1'b1);
    rel_clear();
    fw_en = 0;
    wr(4'h4, 8'h04);
    cyc(2);
    chk({5'h00, grel, frs, smi}, 8'h06);
    rel_clear();
    // timer counts, holds when gated, resumes after the pin stops
    work = 1;
    run = 1;
    cyc(3);
    tick(5);
    rd(4'h8, 8'h05, 1'b1);
    work = 0;
    cyc(3);
    tick(3);
    rd(4'h8, 8'h05, 1'b1);
    work = 1;
    run = 0;
    cyc(3);
    tick(3);
    rd(4'h8, 8'h05, 1'b1);
    run = 1;
    cyc(40);
    tick(300);
    rd(4'h8, 8'h31, 1'b1);
    rd(4'h9, 8'h01, 1'b1);
    rd(4'hA, 8'h00, 1'b1);
    chk({7'h00, tcs}, 8'h00);
    // carry of the 12-bit bench timer: top bit flips at 800h and at the wrap
    tick(1742);
    chk({5'h00, tcs, sci, smi}, 8'h00);
    tick(1);
    chk({5'h00, tcs, sci, smi}, 8'h05);
    wr(4'h4, 8'h01);
    chk({5'h00, tcs, sci, smi}, 8'h06);
    tce = 0;
    cyc(2);
    chk({5'h00, tcs, sci, smi}, 8'h04);
    tcs_clr = 1;
    cyc(1);
    tcs_clr = 0;
    cyc(2);
    chk({7'h00, tcs}, 8'h00);
    tick(2047);
    rd(4'h8, 8'hFF, 1'b1);
    rd(4'h9, 8'h0F, 1'b1);
    chk({7'h00, tcs}, 8'h00);
    tick(1);
    rd(4'h8, 8'h00, 1'b1);
    rd(4'h9, 8'h00, 1'b1);
    chk({7'h00, tcs}, 8'h01);
    // second master reset mid-run clears timer and control
    wr(4'h4, 8'h03);
    sys_rst_i = 1;
    cyc(2);
    sys_rst_i = 0;
    rd(4'h8, 8'h00, 1'b1);
    rd(4'h4, 8'h00, 1'b1);
    finish_test();
  end
endmodule // testbench

`default_nettype wire
